// ### logic/iatc_top.v
// Event-driven transfer chain that sequences intermittent low-power conversion
// ------------------------------------------------------------------------------
// Functional notes
// - Descriptor zero copies byte FD00 into port five register, chains to one.
// - Descriptor one copies word FD04 into settling timer control, ends chain.
// - Short timer underflow starts descriptor zero, one transfer, repeat mode.
// - Conversion end starts descriptor two: result to FC00 buffer, 4, repeat.
// - Descriptor three copies byte FD02 into port five, chains to four.
// - Descriptor four copies word FD06 into timer control, stopping it.
// - Descriptor five copies conversion result into accumulator input.
// - Descriptor six restores accumulator setting from word FD0C.
// - Descriptor seven writes FD08 byte to converter mode two, clearing wake.
// - Descriptor eight writes FD0A byte to converter mode two, ends chain.
// - Short timer underflow triggers both amplifier units through event link.
// - Accumulator adds each input word to its setting, interrupt enabled.
// - Accumulator setting starts at F482 so sums overflow past threshold.
// - Settling timer interrupt starts a conversion in low-power mode.
// - Conversion end stops amplifiers and runs descriptors two to eight.
// - Accumulator overflow raises interrupt and returns to normal operation.
// - Without overflow, return to stop mode after chain completes.
// - Converter in select one-shot mode waits for settling timer trigger.
// - Sensor power pin high means power on, low means off.
// ------------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "iatc_defs.vh"

module iatc_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire timer_underflow_i,
  input wire settling_timer_irq_i,
  input wire conv_end_i,
  input wire [15:0] conv_result_i,
  output reg sensor_power_pin_o,
  output reg [15:0] settling_timer_control_o,
  output reg [7:0] converter_mode_two_o,
  output reg conv_start_o,
  output reg amp_zero_run_o,
  output reg amp_one_run_o,
  output reg acc_irq_o,
  output reg stop_mode_o,
  output reg chain_busy_o,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------------------
  // Chain states
  // ----------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_D0 = 4'h1;
  localparam [3:0] ST_D1 = 4'h2;
  localparam [3:0] ST_D2 = 4'h3;
  localparam [3:0] ST_D3 = 4'h4;
  localparam [3:0] ST_D4 = 4'h5;
  localparam [3:0] ST_D5 = 4'h6;
  localparam [3:0] ST_D6 = 4'h7;
  localparam [3:0] ST_D7 = 4'h8;
  localparam [3:0] ST_D8 = 4'h9;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Sequencer state and software control bits
  reg [3:0] state_q;
  reg [6:0] ctrl_q;
  // Source words that the descriptors copy out
  reg [15:0] word_d0_q;
  reg [15:0] word_d1_q;
  reg [15:0] word_d3_q;
  reg [15:0] word_d4_q;
  reg [15:0] word_d6_q;
  reg [15:0] word_d7_q;
  reg [15:0] word_d8_q;
  // Accumulator setting and last input word
  reg [15:0] acc_setting_q;
  reg [15:0] last_input_q;
  // Result ring and its repeat count
  reg [15:0] buf_q [0:3];
  reg [1:0] buf_idx_q;
  reg [2:0] d2_left_q;
  // Overflow flag and port five image
  reg ovf_q;
  reg [7:0] port_five_q;
  // Write channel holding registers; strobes are kept, writes are full words
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  // Read decode outputs
  reg [31:0] rdata_d;
  reg rok_d;
  // Sum with carry, and write commit strobe
  wire [16:0] acc_sum;
  wire wr_go;

  // ----------------------------------------------------------------------------
  // Accumulator and write commit
  // ----------------------------------------------------------------------------
  // Carry out of bit 15 is the overflow
  assign acc_sum = {1'b0, acc_setting_q} + {1'b0, conv_result_i};
  // Commit waits until the previous response is taken
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

  // ----------------------------------------------------------------------------
  // Descriptor chain sequencer
  // ----------------------------------------------------------------------------
  // One descriptor per clock; activations are ignored while a chain runs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      port_five_q <= 8'h00;
      settling_timer_control_o <= 16'h0000;
      converter_mode_two_o <= 8'h00;
      acc_setting_q <= `IATC_ACC_OFFSET_RST;
      last_input_q <= 16'h0000;
      buf_idx_q <= 2'h0;
      d2_left_q <= `IATC_D2_COUNT;
      ovf_q <= 1'b0;
    end else begin
      // Software writes that land in sequencer-owned registers
      if (wr_go && awaddr_q == `IATC_REG_SETTING) begin
        acc_setting_q <= wdata_q[15:0];
      end
      if (wr_go && awaddr_q == `IATC_REG_CTRL && wdata_q[`IATC_CTRL_CLR_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (wr_go && awaddr_q == `IATC_REG_CTRL && wdata_q[`IATC_CTRL_CMP_EN]) begin
        converter_mode_two_o[`IATC_WAKE_BIT] <= 1'b1;
      end
      // One descriptor per clock
      case (state_q)
        // Idle: underflow wins over conversion end
        ST_IDLE: begin
          if (timer_underflow_i && ctrl_q[`IATC_CTRL_EN_ZERO] && ctrl_q[`IATC_CTRL_TSTART]) begin
            state_q <= ST_D0;
          end else if (conv_end_i && ctrl_q[`IATC_CTRL_EN_TWO]) begin
            state_q <= ST_D2;
          end
        end
        // Sensor power on through port five
        ST_D0: begin
          port_five_q <= word_d0_q[7:0];
          state_q <= ST_D1;
        end
        // Settling timer start word, chain ends
        ST_D1: begin
          settling_timer_control_o <= word_d1_q;
          state_q <= ST_IDLE;
        end
        // Result into the ring buffer
        ST_D2: begin
          buf_q[buf_idx_q] <= conv_result_i;
          buf_idx_q <= buf_idx_q + 2'h1;
          // Repeat mode: count reloads after the fourth transfer
          d2_left_q <= (d2_left_q == 3'h1) ? `IATC_D2_COUNT : d2_left_q - 3'h1;
          state_q <= ST_D3;
        end
        // Sensor power off through port five
        ST_D3: begin
          port_five_q <= word_d3_q[7:0];
          state_q <= ST_D4;
        end
        // Settling timer stop word
        ST_D4: begin
          settling_timer_control_o <= word_d4_q;
          state_q <= ST_D5;
        end
        // Result into the accumulator, carry sets overflow
        ST_D5: begin
          last_input_q <= conv_result_i;
          acc_setting_q <= acc_sum[15:0];
          if (acc_sum[16]) begin
            ovf_q <= 1'b1;
          end
          state_q <= ST_D6;
        end
        // Threshold offset reloaded for the next sum
        ST_D6: begin
          acc_setting_q <= word_d6_q;
          state_q <= ST_D7;
        end
        // Wake control cleared
        ST_D7: begin
          converter_mode_two_o <= word_d7_q[7:0];
          state_q <= ST_D8;
        end
        // Wake control set again, chain ends
        ST_D8: begin
          converter_mode_two_o <= word_d8_q[7:0];
          state_q <= ST_IDLE;
        end
        // Unused codes fall back to idle
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Pins and side effects of the chain
  // ----------------------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensor_power_pin_o <= 1'b0;
      conv_start_o <= 1'b0;
      amp_zero_run_o <= 1'b0;
      amp_one_run_o <= 1'b0;
      acc_irq_o <= 1'b0;
      stop_mode_o <= 1'b0;
      chain_busy_o <= 1'b0;
    end else begin
      // Pin follows bit seven of port five
      sensor_power_pin_o <= port_five_q[`IATC_SENSOR_BIT];
      // Conversion starts on timer trigger only when armed
      conv_start_o <= settling_timer_irq_i & ctrl_q[`IATC_CTRL_CMP_EN]
                      & converter_mode_two_o[`IATC_WAKE_BIT];
      // Amplifiers start on underflow, stop on conversion end
      if (timer_underflow_i) begin
        amp_zero_run_o <= ctrl_q[`IATC_CTRL_AMP0];
        amp_one_run_o <= ctrl_q[`IATC_CTRL_AMP1];
      end else if (conv_end_i) begin
        amp_zero_run_o <= 1'b0;
        amp_one_run_o <= 1'b0;
      end
      // Interrupt mirrors the overflow flag
      acc_irq_o <= ovf_q;
      // Stop mode resumes once idle without overflow
      stop_mode_o <= (state_q == ST_IDLE) & ~ovf_q & ctrl_q[`IATC_CTRL_TSTART];
      // Busy while any descriptor is pending
      chain_busy_o <= (state_q != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IATC_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= 7'h00;
      word_d0_q <= `IATC_WORD_D0_RST;
      word_d1_q <= `IATC_WORD_D1_RST;
      word_d3_q <= `IATC_WORD_OFF_RST;
      word_d4_q <= `IATC_WORD_OFF_RST;
      word_d6_q <= `IATC_ACC_OFFSET_RST;
      word_d7_q <= `IATC_WORD_OFF_RST;
      word_d8_q <= `IATC_WORD_D8_RST;
    end else begin
      // Each ready pulses one cycle for a waiting valid
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      // Capture the address
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      // Capture the data
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // Response leaves once taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Commit once address and data are both held
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IATC_RESP_OKAY;
        // Decode; unmapped offsets answer with an error
        case (awaddr_q)
          `IATC_REG_CTRL: ctrl_q <= {1'b0, wdata_q[5:0]};
          `IATC_REG_SETTING: ctrl_q <= ctrl_q;
          `IATC_REG_WORD_D0: word_d0_q <= wdata_q[15:0];
          `IATC_REG_WORD_D1: word_d1_q <= wdata_q[15:0];
          `IATC_REG_WORD_D3: word_d3_q <= wdata_q[15:0];
          `IATC_REG_WORD_D4: word_d4_q <= wdata_q[15:0];
          `IATC_REG_WORD_D6: word_d6_q <= wdata_q[15:0];
          `IATC_REG_WORD_D7: word_d7_q <= wdata_q[15:0];
          `IATC_REG_WORD_D8: word_d8_q <= wdata_q[15:0];
          default: s_axi_bresp <= `IATC_RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------------
  // Read decode of the register map
  always @* begin
    // Unmapped reads return zero with an error
    rdata_d = 32'h0000_0000;
    rok_d = 1'b1;
    case (s_axi_araddr)
      `IATC_REG_CTRL: rdata_d = {25'h0, ctrl_q};
      // Status: overflow, repeat count, state, pins
      `IATC_REG_STATUS: rdata_d = {20'h0, ovf_q, d2_left_q, state_q, sensor_power_pin_o,
                                   stop_mode_o, amp_one_run_o, amp_zero_run_o};
      `IATC_REG_LAST: rdata_d = {16'h0, last_input_q};
      `IATC_REG_SETTING: rdata_d = {16'h0, acc_setting_q};
      `IATC_REG_WORD_D0: rdata_d = {16'h0, word_d0_q};
      `IATC_REG_WORD_D1: rdata_d = {16'h0, word_d1_q};
      `IATC_REG_WORD_D3: rdata_d = {16'h0, word_d3_q};
      `IATC_REG_WORD_D4: rdata_d = {16'h0, word_d4_q};
      `IATC_REG_WORD_D6: rdata_d = {16'h0, word_d6_q};
      `IATC_REG_WORD_D7: rdata_d = {16'h0, word_d7_q};
      `IATC_REG_WORD_D8: rdata_d = {16'h0, word_d8_q};
      // Ring index and the newest stored result
      `IATC_REG_BUF: rdata_d = {14'h0, buf_idx_q, buf_q[buf_idx_q - 2'h1]};
      default: rok_d = 1'b0;
    endcase
  end

  // Read handshake: one item in flight
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IATC_RESP_OKAY;
    end else begin
      // Address accepted one cycle after it is offered
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      // Data registered at acceptance, held until taken
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rok_d ? `IATC_RESP_OKAY : `IATC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // iatc_top
`default_nettype wire

// ### shared/iatc_defs.vh
// Constants for the intermittent converter transfer chain block
`ifndef IATC_DEFS_VH
`define IATC_DEFS_VH
// Descriptor table: source and destination addresses
`define IATC_D0_SRC 16'hFD00
`define IATC_D1_SRC 16'hFD04
`define IATC_D3_SRC 16'hFD02
`define IATC_D4_SRC 16'hFD06
`define IATC_D6_SRC 16'hFD0C
`define IATC_D7_SRC 16'hFD08
`define IATC_D8_SRC 16'hFD0A
`define IATC_BUF_DST 16'hFC00
`define IATC_PORT5_ADR 16'hFF05
`define IATC_CONV_RES_ADR 16'hFF1E
`define IATC_STC_ADR 16'hFF90
`define IATC_ACC_IN_ADR 16'h0512
`define IATC_ACC_SET_ADR 16'h0514
`define IATC_CMODE2_ADR 16'h0010
`define IATC_D2_COUNT 3'h4
// Reset and constant values
`define IATC_ACC_OFFSET_RST 16'hF482
`define IATC_TIMER_RUN_BIT 15
`define IATC_WAKE_BIT 2
`define IATC_SENSOR_BIT 7
// Reset values of the descriptor source words
`define IATC_WORD_D0_RST 16'h0080
`define IATC_WORD_D1_RST 16'h8000
`define IATC_WORD_OFF_RST 16'h0000
`define IATC_WORD_D8_RST 16'h0004
// AXI4-Lite register byte offsets
`define IATC_REG_CTRL 8'h00
`define IATC_REG_STATUS 8'h04
`define IATC_REG_LAST 8'h08
`define IATC_REG_SETTING 8'h0C
`define IATC_REG_WORD_D0 8'h10
`define IATC_REG_WORD_D1 8'h14
`define IATC_REG_WORD_D3 8'h18
`define IATC_REG_WORD_D4 8'h1C
`define IATC_REG_WORD_D6 8'h20
`define IATC_REG_WORD_D7 8'h24
`define IATC_REG_WORD_D8 8'h28
`define IATC_REG_BUF 8'h2C
// Control register fields
`define IATC_CTRL_EN_ZERO 0
`define IATC_CTRL_EN_TWO 1
`define IATC_CTRL_CMP_EN 2
`define IATC_CTRL_AMP0 3
`define IATC_CTRL_AMP1 4
`define IATC_CTRL_TSTART 5
`define IATC_CTRL_CLR_OVF 6
`define IATC_RESP_OKAY 2'h0
`define IATC_RESP_SLVERR 2'h2
`endif

// ### bench/iatc_chk.sv
// Port assertions for the transfer chain top
`timescale 1ns/10ps
`default_nettype none
module iatc_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic timer_underflow_i,
  input wire logic settling_timer_irq_i,
  input wire logic conv_end_i,
  input wire logic [15:0] settling_timer_control_o,
  input wire logic [7:0] converter_mode_two_o,
  input wire logic conv_start_o,
  input wire logic amp_zero_run_o,
  input wire logic amp_one_run_o,
  input wire logic acc_irq_o,
  input wire logic stop_mode_o,
  input wire logic chain_busy_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Causes of conversion, amplifier, timer, wake and overflow changes, with the cycle spacing of the chains
  a_conv_trig: assert property (
    conv_start_o |-> $past(settling_timer_irq_i) && $past(converter_mode_two_o[2]))
    else $error("stray conversion start");
  a_amp_rise: assert property (
    $rose(amp_zero_run_o) || $rose(amp_one_run_o) |-> $past(timer_underflow_i))
    else $error("amplifier start without underflow");
  a_amp_stop: assert property (
    $fell(amp_zero_run_o) || $fell(amp_one_run_o) |-> $past(conv_end_i))
    else $error("amplifier stop without conversion end");
  a_timer_run: assert property (
    $rose(settling_timer_control_o[15]) |-> $past(timer_underflow_i, 2)
    || $past(timer_underflow_i, 3) || $past(timer_underflow_i, 4))
    else $error("timer start out of place");
  a_timer_stop: assert property (
    $fell(settling_timer_control_o[15]) |-> $past(conv_end_i, 3)
    || $past(conv_end_i, 4) || $past(conv_end_i, 5))
    else $error("timer stop out of place");
  a_chain_end: assert property (
    $rose(chain_busy_o) |-> ##[1:9] !chain_busy_o)
    else $error("chain did not end");
  a_wake_rearm: assert property (
    $fell(converter_mode_two_o[2]) |=> converter_mode_two_o[2])
    else $error("wake bit not set again");
  a_ovf_cause: assert property (
    $rose(acc_irq_o) |-> $past(chain_busy_o) || $past(chain_busy_o, 2))
    else $error("overflow outside a chain");
  a_ovf_wake: assert property (
    acc_irq_o && $past(acc_irq_o) |-> !stop_mode_o)
    else $error("stop mode during overflow");
  // Main scenarios reached
  c_conv: cover property ($rose(conv_start_o));
  c_ovf: cover property ($rose(acc_irq_o));
  c_chain: cover property ($fell(chain_busy_o));
endmodule // iatc_chk
bind iatc_top iatc_chk u_chk (.clk_i, .arst_n_i, .timer_underflow_i, .settling_timer_irq_i,
  .conv_end_i, .settling_timer_control_o, .converter_mode_two_o, .conv_start_o,
  .amp_zero_run_o, .amp_one_run_o, .acc_irq_o, .stop_mode_o, .chain_busy_o);
`default_nettype wire

// ### bench/iatc_far.sv
// Behavioural settling timer and converter facing the transfer chain
`timescale 1ns/10ps
`default_nettype none
module iatc_far #(
  parameter int SETTLE = 6,
  parameter int CONV = 5
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] timer_ctrl_i,
  input wire logic conv_start_i,
  input wire logic [15:0] result_i,
  output logic irq_o,
  output logic conv_end_o,
  output logic [15:0] res_o
);
  logic [7:0] cnt_q;
  logic [7:0] cv_q;
  // Timer counts only while its run bit is set; stop word clears it
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      cnt_q <= timer_ctrl_i[15] ? cnt_q + 8'h01 : 8'h00;
      irq_o <= timer_ctrl_i[15] && cnt_q == 8'(SETTLE);
    end
  end
  // Conversion ends CONV cycles after its trigger; result kept as a level
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cv_q <= 8'h00;
      conv_end_o <= 1'b0;
      res_o <= 16'h0000;
    end else begin
      cv_q <= conv_start_i ? 8'(CONV) : cv_q - {7'h00, cv_q != 8'h00};
      conv_end_o <= cv_q == 8'h01;
      if (cv_q == 8'h01) res_o <= result_i;
    end
  end
endmodule // iatc_far
`default_nettype wire

// ### bench/tb_intermittent_adc_transfer_chain.sv
// Self-checking bench for the intermittent converter transfer chain
`timescale 1ns/10ps
`default_nettype none
`include "iatc_defs.vh"
module tb_intermittent_adc_transfer_chain;
  logic clk_i, arst_n_i, timer_underflow_i, settling_timer_irq_i, conv_end_i;
  logic [15:0] conv_result_i, result, settling_timer_control_o;
  logic sensor_power_pin_o, conv_start_o, amp_zero_run_o, amp_one_run_o;
  logic acc_irq_o, stop_mode_o, chain_busy_o;
  logic [7:0] converter_mode_two_o, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] vals [4] = '{16'h0010, 16'h0B7D, 16'h0A00, 16'h0001};
  int n_fail = 0;
  int cmp_count = 0;
  int n_conv = 0;
  iatc_top DUT (.clk_i, .arst_n_i, .timer_underflow_i, .settling_timer_irq_i, .conv_end_i,
    .conv_result_i, .sensor_power_pin_o, .settling_timer_control_o, .converter_mode_two_o,
    .conv_start_o, .amp_zero_run_o, .amp_one_run_o, .acc_irq_o, .stop_mode_o, .chain_busy_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  iatc_far FAR (.clk_i, .arst_n_i, .timer_ctrl_i(settling_timer_control_o),
    .conv_start_i(conv_start_o), .result_i(result), .irq_o(settling_timer_irq_i),
    .conv_end_o(conv_end_i), .res_o(conv_result_i));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  // Bus read with masked data compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk(s_axi_rresp, er);
  endtask
  // Reset state and address decode refusal
  task automatic t_reset;
    chk({sensor_power_pin_o, settling_timer_control_o, converter_mode_two_o}, 32'h0);
    chk({amp_zero_run_o, amp_one_run_o, acc_irq_o, stop_mode_o, chain_busy_o}, 32'h0);
    rd(`IATC_REG_SETTING, 32'hF482, 32'hFFFFFFFF, `IATC_RESP_OKAY);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, `IATC_RESP_SLVERR);
    wr(8'h30, 32'h0000FFFF, `IATC_RESP_SLVERR);
  endtask
  // One wake period: sensor on, settle, convert, then the seven-step tidy-up
  task automatic t_cycle(input logic [15:0] res, input logic ovf);
    logic [31:0] st_exp;
    @(posedge clk_i);
    result <= res;
    timer_underflow_i <= 1'b1;
    @(posedge clk_i);
    timer_underflow_i <= 1'b0;
    wait (settling_timer_irq_i);
    chk(sensor_power_pin_o, 32'h1);
    chk(settling_timer_control_o, 32'h8000);
    chk({amp_one_run_o, amp_zero_run_o}, 32'h3);
    wait (conv_end_i);
    n_conv++;
    @(negedge chain_busy_o);
    repeat (2) @(posedge clk_i);
    #1;
    chk(sensor_power_pin_o, 32'h0);
    chk(settling_timer_control_o, 32'h0);
    chk({amp_one_run_o, amp_zero_run_o}, 32'h0);
    chk(converter_mode_two_o, 32'h04);
    chk(acc_irq_o, ovf);
    chk(stop_mode_o, !ovf);
    rd(`IATC_REG_LAST, res, 32'hFFFFFFFF, `IATC_RESP_OKAY);
    rd(`IATC_REG_SETTING, 32'hF482, 32'hFFFFFFFF, `IATC_RESP_OKAY);
    rd(`IATC_REG_BUF, {14'h0, n_conv[1:0], res}, 32'hFFFFFFFF, `IATC_RESP_OKAY);
    // Repeat count reloads to four after every fourth store
    st_exp = (ovf ? 32'h800 : 32'h4) | ((4 - n_conv % 4) << 8);
    rd(`IATC_REG_STATUS, st_exp, 32'hFFFFFFFF, `IATC_RESP_OKAY);
  endtask
  // Arm both chains, comparator, amplifiers and timer start in one write, then check the wake bit
  task automatic t_arm;
    wr(`IATC_REG_CTRL, 32'h0000003F, `IATC_RESP_OKAY);
    @(posedge clk_i);
    #1;
    chk(converter_mode_two_o, 32'h04);
  endtask
  // Software clears the overflow and the block may sleep again
  task automatic t_clear;
    wr(`IATC_REG_CTRL, 32'h0000007F, `IATC_RESP_OKAY);
    repeat (2) @(posedge clk_i);
    #1;
    chk(acc_irq_o, 32'h0);
    chk(stop_mode_o, 32'h1);
  endtask
  // Underflow during the conversion chain starts no new chain
  task automatic t_busy;
    @(posedge clk_i);
    timer_underflow_i <= 1'b1;
    @(posedge clk_i);
    timer_underflow_i <= 1'b0;
    wait (conv_end_i);
    @(posedge clk_i);
    timer_underflow_i <= 1'b1;
    @(posedge clk_i);
    timer_underflow_i <= 1'b0;
    @(negedge chain_busy_o);
    repeat (2) @(posedge clk_i);
    #1;
    chk(sensor_power_pin_o, 32'h0);
    chk(settling_timer_control_o, 32'h0);
    chk(chain_busy_o, 32'h0);
    chk({amp_one_run_o, amp_zero_run_o}, 32'h3);
  endtask
  // Verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Main sequence: arm, sum up to the threshold, overflow, clear, sleep again
  initial begin
    {arst_n_i, timer_underflow_i, result} = 18'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_arm;
    foreach (vals[i]) t_cycle(vals[i], 1'b0);
    t_cycle(16'h0B7E, 1'b1);
    t_clear;
    t_cycle(16'h0002, 1'b0);
    t_busy;
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    complete_run;
  end
endmodule // tb_intermittent_adc_transfer_chain
`default_nettype wire
